// ==== verilog/snh_pkg.sv ====
// Shared constants and types for the serial NAND program, erase and OTP host controller.
package snh_pkg;
    // ************************************************************
    // Opcodes and feature addresses
    // ************************************************************
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_LOAD = 8'h02;
    localparam logic [7:0] OP_LOAD4 = 8'h32;
    localparam logic [7:0] OP_RLD = 8'h84;
    localparam logic [7:0] OP_RLD4 = 8'hc4;
    localparam logic [7:0] OP_RLDQ = 8'h72;
    localparam logic [7:0] OP_PEXE = 8'h10;
    localparam logic [7:0] OP_PREAD = 8'h13;
    localparam logic [7:0] OP_ERASE = 8'hd8;
    localparam logic [7:0] OP_RST = 8'hff;
    localparam logic [7:0] OP_GETF = 8'h0f;
    localparam logic [7:0] OP_SETF = 8'h1f;
    localparam logic [7:0] FA_FEAT = 8'hb0;
    localparam logic [7:0] FA_STAT = 8'hc0;
    // ************************************************************
    // Field positions, lengths and counts
    // ************************************************************
    localparam int QE_B = 0;
    localparam int ECC_B = 4;
    localparam int OEN_B = 6;
    localparam int OPRT_B = 7;
    localparam int BUSY_B = 0;
    localparam logic [11:0] LEN_FULL = 12'd2176;
    localparam logic [11:0] LEN_ECC = 12'd2112;
    localparam logic [2:0] OTP_PAGES = 3'd4;
    localparam logic [5:0] OPC_BITS = 6'd8;
    localparam logic [5:0] AB_ROW = 6'd24;
    localparam logic [5:0] AB_COL = 6'd16;
    localparam logic [5:0] AB_FA = 6'd8;
    localparam logic [5:0] QHDR_BITS = 6'd16;
    localparam logic [3:0] BYTE_BITS = 4'd8;
    localparam logic [2:0] DIV_LAST = 3'd7;
    localparam logic [3:0] GAP_CYC = 4'd8;
    localparam logic [3:0] SO_IDLE = 4'hc;
    localparam logic [3:0] SOE_IDLE = 4'hd;
    localparam logic [3:0] SOE_QUAD = 4'hf;
    localparam int CLK_NS = 20;
    localparam int RST_WAIT_NS = 300;
    localparam logic [4:0] RST_WAIT_CYC = 5'((RST_WAIT_NS + CLK_NS - 1) / CLK_NS);
    // User command kinds.
    typedef enum logic [2:0] {
        K_LOAD, K_RLOAD, K_PROG, K_ERASE, K_PREAD, K_RESET, K_SETF, K_GETF
    } snh_kind_type;
endpackage

// ==== verilog/snh_host.sv ====
// Host controller sequencing program, erase, reset and OTP commands on a serial NAND.
`timescale 1ns/1ps
module snh_host (
    input wire clk_sys,
    input wire rst_n,
    input wire ce,
    input wire cmd_valid,
    input snh_pkg::snh_kind_type cmd_kind,
    input wire cmd_quad,
    input wire cmd_qio,
    input wire [23:0] cmd_addr,
    input wire [11:0] cmd_len,
    input wire [7:0] cmd_data,
    output wire cmd_ready,
    output wire done,
    output wire refused,
    output wire [7:0] status,
    input wire wr_valid,
    input wire [7:0] wr_data,
    output wire wr_ready,
    output wire chip_select_n,
    output wire link_sclk,
    input wire serial_line_zero_i,
    output wire serial_line_zero_o,
    output wire serial_line_zero_oe,
    input wire serial_line_one_i,
    output wire serial_line_one_o,
    output wire serial_line_one_oe,
    input wire serial_line_two_i,
    output wire serial_line_two_o,
    output wire serial_line_two_oe,
    input wire serial_line_three_i,
    output wire serial_line_three_o,
    output wire serial_line_three_oe
);
    // ************************************************************
    // State
    // ************************************************************
    typedef enum logic [2:0] {
        S_IDLE, S_CMD2, S_RWAIT, S_POLL, S_PCHK, S_LAST
    } snh_st_type;

    typedef struct packed {
        snh_st_type st;
        snh_pkg::snh_kind_type kind;
        logic [23:0] row;
        logic [7:0] op;
        logic [7:0] last_op;
        logic act;
        logic cs_n;
        logic sclk;
        logic [2:0] div;
        logic [3:0] gap;
        logic [31:0] sh;
        logic [5:0] hbits;
        logic q4h;
        logic q4d;
        logic rd;
        logic [7:0] dbyte;
        logic [3:0] dbits;
        logic [11:0] nleft;
        logic [11:0] need;
        logic [7:0] rx;
        logic [7:0] pend;
        logic pend_v;
        logic wr_ready;
        logic [4:0] wcnt;
        logic qe;
        logic ecc;
        logic oen;
        logic oprt;
        logic locked;
        logic cached;
        logic [2:0] otp_pg;
        logic [3:0] so;
        logic [3:0] soe;
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic cmd_ready;
        logic done;
        logic refused;
        logic [7:0] status;
    } snh_state_type;

    snh_state_type s;
    snh_state_type n;

    // Starts one chip-select frame: opcode, address bits, then n data bytes.
    function automatic snh_state_type launch(input snh_state_type x, input logic [7:0] op,
            input logic [23:0] a, input logic [5:0] ab, input logic q4h,
            input logic [11:0] nb, input logic q4d, input logic rd);
        snh_state_type y;
        y = x;
        y.op = op;
        y.sh = {op, a};
        y.hbits = snh_pkg::OPC_BITS + ab;
        y.q4h = q4h;
        y.q4d = q4d;
        y.rd = rd;
        y.nleft = nb;
        y.need = rd ? 12'd0 : nb;
        y.pend_v = 1'b0;
        y.act = 1'b1;
        y.cs_n = 1'b0;
        y.div = 3'd0;
        return y;
    endfunction

    logic l4;
    logic hdr;
    logic seg_end;
    logic idle;
    logic q;
    logic o4;
    logic [5:0] w;
    logic [11:0] nl;
    logic [11:0] cap;
    logic [11:0] room;
    logic [11:0] len;
    logic [7:0] lop;
    logic [3:0] bits;

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb begin
        n = s;
        n.done = 1'b0;
        n.refused = 1'b0;
        n.sync1 = {serial_line_three_i, serial_line_two_i, serial_line_one_i, serial_line_zero_i};
        n.sync2 = s.sync1;
        idle = !s.act && s.gap == 4'd0;
        // The header goes quad only for its address part, so the opcode stays single-line.
        l4 = (s.hbits != 6'd0) ? (s.q4h && s.hbits <= snh_pkg::QHDR_BITS) : s.q4d;
        w = l4 ? 6'd4 : 6'd1;
        hdr = s.hbits != 6'd0;
        seg_end = hdr ? (s.hbits == w) : (s.dbits == w[3:0]);
        nl = hdr ? s.nleft : s.nleft - 12'd1;
        if (s.gap != 4'd0) begin
            n.gap = s.gap - 4'd1;
        end
        // Bit engine: one serial clock every eight system clocks, advancing on the last one.
        if (s.act) begin
            n.div = s.div + 3'd1;
            if (s.div == snh_pkg::DIV_LAST) begin
                // Stalling with the clock high is legal and keeps the byte stream whole.
                if (seg_end && nl != 12'd0 && !s.rd && !s.pend_v) begin
                    n.div = s.div;
                end else begin
                    if (hdr) begin
                        n.sh = l4 ? s.sh << 4 : s.sh << 1;
                        n.hbits = s.hbits - w;
                    end else begin
                        n.dbyte = l4 ? s.dbyte << 4 : s.dbyte << 1;
                        n.dbits = s.dbits - w[3:0];
                        n.rx = {s.rx[6:0], s.sync2[1]};
                    end
                    if (seg_end) begin
                        n.nleft = nl;
                        if (nl == 12'd0) begin
                            n.act = 1'b0;
                            n.cs_n = 1'b1;
                            n.gap = snh_pkg::GAP_CYC;
                            n.last_op = s.op;
                        end else begin
                            n.dbits = snh_pkg::BYTE_BITS;
                            if (!s.rd) begin
                                n.dbyte = s.pend;
                                n.pend_v = 1'b0;
                            end
                        end
                    end
                end
            end
        end
        // One-byte prefetch of user write data.
        if (s.wr_ready && wr_valid) begin
            n.pend = wr_data;
            n.pend_v = 1'b1;
            n.need = s.need - 12'd1;
        end
        // Loads are cut to the room left in the cache from the start column.
        cap = s.ecc ? snh_pkg::LEN_ECC : snh_pkg::LEN_FULL;
        room = cap - cmd_addr[11:0];
        len = (cmd_len > room) ? room : cmd_len;
        q = cmd_quad || (cmd_kind == snh_pkg::K_RLOAD && cmd_qio);
        if (cmd_kind == snh_pkg::K_LOAD) begin
            lop = cmd_quad ? snh_pkg::OP_LOAD4 : snh_pkg::OP_LOAD;
        end else begin
            lop = cmd_qio ? snh_pkg::OP_RLDQ : (cmd_quad ? snh_pkg::OP_RLD4 : snh_pkg::OP_RLD);
        end
        // Command sequencer.
        case (s.st)
            S_IDLE: begin
                if (cmd_valid) begin
                    n.kind = cmd_kind;
                    n.row = cmd_addr;
                    case (cmd_kind)
                        snh_pkg::K_LOAD, snh_pkg::K_RLOAD: begin
                            if ((q && !s.qe) || cmd_addr[11:0] >= cap) begin
                                n.refused = 1'b1;
                            end else if (cmd_kind == snh_pkg::K_RLOAD && !s.cached) begin
                                n.refused = 1'b1;
                            end else begin
                                n = launch(n, lop, {4'h0, cmd_addr[11:0], 8'h00},
                                    snh_pkg::AB_COL, cmd_qio && cmd_kind == snh_pkg::K_RLOAD,
                                    len, q, 1'b0);
                                n.st = S_LAST;
                            end
                        end
                        snh_pkg::K_PROG: begin
                            // Once protected, the OTP region takes no more programming.
                            if (s.oen && (s.locked || (!s.oprt && (s.otp_pg == snh_pkg::OTP_PAGES
                                    || cmd_addr != {21'd0, s.otp_pg})))) begin
                                n.refused = 1'b1;
                            end else begin
                                n = launch(n, snh_pkg::OP_WREN, 24'h0, 6'd0, 1'b0, 12'd0,
                                    1'b0, 1'b0);
                                n.st = S_CMD2;
                            end
                        end
                        snh_pkg::K_ERASE: begin
                            if (s.oen) begin
                                n.refused = 1'b1;
                            end else begin
                                n = launch(n, snh_pkg::OP_WREN, 24'h0, 6'd0, 1'b0, 12'd0,
                                    1'b0, 1'b0);
                                n.st = S_CMD2;
                            end
                        end
                        snh_pkg::K_PREAD: begin
                            n = launch(n, snh_pkg::OP_PREAD, cmd_addr, snh_pkg::AB_ROW, 1'b0,
                                12'd0, 1'b0, 1'b0);
                            n.st = S_POLL;
                        end
                        snh_pkg::K_RESET: begin
                            n = launch(n, snh_pkg::OP_RST, 24'h0, 6'd0, 1'b0, 12'd0, 1'b0, 1'b0);
                            n.wcnt = snh_pkg::RST_WAIT_CYC;
                            n.st = S_RWAIT;
                        end
                        snh_pkg::K_SETF: begin
                            n = launch(n, snh_pkg::OP_SETF, {cmd_addr[7:0], 16'h0},
                                snh_pkg::AB_FA, 1'b0, 12'd1, 1'b0, 1'b0);
                            n.pend = cmd_data;
                            n.pend_v = 1'b1;
                            n.need = 12'd0;
                            if (cmd_addr[7:0] == snh_pkg::FA_FEAT) begin
                                n.qe = cmd_data[snh_pkg::QE_B];
                                n.ecc = cmd_data[snh_pkg::ECC_B];
                                n.oen = cmd_data[snh_pkg::OEN_B];
                                n.oprt = cmd_data[snh_pkg::OPRT_B];
                            end
                            n.st = S_LAST;
                        end
                        default: begin
                            n = launch(n, snh_pkg::OP_GETF, {cmd_addr[7:0], 16'h0},
                                snh_pkg::AB_FA, 1'b0, 12'd1, 1'b0, 1'b1);
                            n.st = S_LAST;
                        end
                    endcase
                end
            end
            S_CMD2: begin
                if (idle) begin
                    n = launch(n, (s.kind == snh_pkg::K_PROG) ? snh_pkg::OP_PEXE :
                        snh_pkg::OP_ERASE, s.row, snh_pkg::AB_ROW, 1'b0, 12'd0, 1'b0, 1'b0);
                    n.st = S_POLL;
                end
            end
            S_RWAIT: begin
                // The busy bit is unreliable right after reset, so the first poll waits.
                if (!s.act && s.wcnt != 5'd0) begin
                    n.wcnt = s.wcnt - 5'd1;
                end else if (idle) begin
                    n.st = S_POLL;
                end
            end
            S_POLL: begin
                if (idle) begin
                    n = launch(n, snh_pkg::OP_GETF, {snh_pkg::FA_STAT, 16'h0}, snh_pkg::AB_FA,
                        1'b0, 12'd1, 1'b0, 1'b1);
                    n.st = S_PCHK;
                end
            end
            S_PCHK: begin
                if (idle) begin
                    n.status = s.rx;
                    if (s.rx[snh_pkg::BUSY_B]) begin
                        n.st = S_POLL;
                    end else begin
                        n.done = 1'b1;
                        n.st = S_IDLE;
                        n.cached = (s.kind == snh_pkg::K_PREAD);
                        if (s.kind == snh_pkg::K_PROG && s.oen) begin
                            if (s.oprt) begin
                                n.locked = 1'b1;
                            end else begin
                                n.otp_pg = s.otp_pg + 3'd1;
                            end
                        end
                    end
                end
            end
            default: begin
                if (idle) begin
                    // A feature read of the OTP byte tells whether the region was locked.
                    if (s.kind == snh_pkg::K_GETF) begin
                        n.status = s.rx;
                        if (s.row[7:0] == snh_pkg::FA_FEAT) begin
                            n.qe = s.rx[snh_pkg::QE_B];
                            n.ecc = s.rx[snh_pkg::ECC_B];
                            n.oen = s.rx[snh_pkg::OEN_B];
                            n.oprt = s.rx[snh_pkg::OPRT_B];
                            n.locked = s.locked || s.rx[snh_pkg::OPRT_B];
                        end
                    end
                    n.done = 1'b1;
                    n.st = S_IDLE;
                end
            end
        endcase
        // Pin drive is computed from the next state so every output is a flop.
        o4 = (n.hbits != 6'd0) ? (n.q4h && n.hbits <= snh_pkg::QHDR_BITS) : n.q4d;
        bits = (n.hbits != 6'd0) ? n.sh[31:28] : n.dbyte[7:4];
        n.so = snh_pkg::SO_IDLE;
        n.soe = snh_pkg::SOE_IDLE;
        if (n.act) begin
            if (o4 && !n.rd) begin
                n.so = bits;
                n.soe = snh_pkg::SOE_QUAD;
            end else begin
                n.so[0] = bits[3];
            end
        end
        n.sclk = n.act && n.div[2];
        n.wr_ready = n.act && !n.rd && !n.pend_v && n.need != 12'd0;
        n.cmd_ready = n.st == S_IDLE;
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
            s.cs_n <= 1'b1;
            s.so <= snh_pkg::SO_IDLE;
            s.soe <= snh_pkg::SOE_IDLE;
            s.cmd_ready <= 1'b1;
        end else if (ce) begin
            s <= n;
        end
    end

    assign cmd_ready = s.cmd_ready;
    assign done = s.done;
    assign refused = s.refused;
    assign status = s.status;
    assign wr_ready = s.wr_ready;
    assign chip_select_n = s.cs_n;
    assign link_sclk = s.sclk;
    assign serial_line_zero_o = s.so[0];
    assign serial_line_one_o = s.so[1];
    assign serial_line_two_o = s.so[2];
    assign serial_line_three_o = s.so[3];
    assign serial_line_zero_oe = s.soe[0];
    assign serial_line_one_oe = s.soe[1];
    assign serial_line_two_oe = s.soe[2];
    assign serial_line_three_oe = s.soe[3];

    // ************************************************************
    // Checks
    // ************************************************************
    a_quad_needs_qe: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!s.cs_n && s.soe == snh_pkg::SOE_QUAD) |-> s.qe) else $error("quad lanes without qe");
    a_load_cap: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $fell(s.cs_n) |-> s.nleft <= (s.ecc ? snh_pkg::LEN_ECC : snh_pkg::LEN_FULL))
        else $error("load exceeds cache");
    a_exec_wren: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ($fell(s.cs_n) && (s.op == snh_pkg::OP_PEXE || s.op == snh_pkg::OP_ERASE))
        |-> s.last_op == snh_pkg::OP_WREN) else $error("execute without write enable");
    a_exec_frame: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ($fell(s.cs_n) && s.op == snh_pkg::OP_PEXE) |-> s.hbits == 6'd32 ##1 !s.cs_n [*8])
        else $error("execute frame too short");
    a_rload_cached: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ($fell(s.cs_n) && (s.op == snh_pkg::OP_RLD || s.op == snh_pkg::OP_RLD4
        || s.op == snh_pkg::OP_RLDQ))
        |-> s.cached && s.hbits == 6'd24) else $error("random load outside data move");
    a_qio_lanes: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ($fell(s.cs_n) && s.op == snh_pkg::OP_RLDQ) |-> s.q4h && s.q4d && s.qe)
        else $error("quad io load not on four lines");
    a_reset_wait: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (s.st == S_RWAIT && !s.act && s.wcnt != 5'd0) |=> s.cs_n && s.st != S_POLL)
        else $error("status polled too early after reset");
    a_poll_start: assert property (@(posedge clk_sys) disable iff (!rst_n || !ce)
        (s.st == S_POLL && !s.act && s.gap == 4'd0) |=> $fell(s.cs_n) && s.op == snh_pkg::OP_GETF)
        else $error("status poll not started");
    a_otp_erase: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ($fell(s.cs_n) && s.op == snh_pkg::OP_ERASE) |-> !s.oen) else $error("erase in otp mode");
endmodule

// ==== verification/snh_nand_model.sv ====
// Behavioural serial NAND device that answers the host controller in tests.
`timescale 1ns/1ps
module snh_nand_model (
    input wire clk_sys,
    input wire chip_select_n,
    input wire link_sclk,
    input wire din,
    output logic dout
);
    logic [7:0] sh = 8'h00;
    logic [7:0] op = 8'h00;
    logic [7:0] fa = 8'h00;
    logic [7:0] feat = 8'h00;
    logic [7:0] rd;
    logic write_permit_latch = 1'b0;
    // Protect sticks once a program execute locks it; a fresh part starts unprotected.
    logic prot = 1'b0;
    int nb = 0;
    int busy = 0;
    initial dout = 1'b0;
    // Shift in host bits on rising edges, most significant bit first.
    always @(posedge link_sclk) begin
        if (!chip_select_n) begin
            sh = {sh[6:0], din};
            nb = nb + 1;
            if (nb == 8) op = sh;
            if (nb == 16) fa = sh;
        end
    end
    // Status or feature byte goes out after the address byte is in, busy or not.
    always @(negedge link_sclk) begin
        if (!chip_select_n && op == 8'h0f && nb >= 16 && nb < 24) begin
            rd = (fa == 8'hc0) ? {6'h00, write_permit_latch, busy != 0} : (feat | {prot, 7'h00});
            dout = rd[23 - nb];
        end
    end
    // Act on a finished frame; a released line flips so stale data never looks valid.
    always @(posedge chip_select_n) begin
        dout = ~dout;
        if (op == 8'h06) write_permit_latch = 1'b1;
        if ((op == 8'h10 || op == 8'hd8) && write_permit_latch) busy = 200;
        if (op == 8'h10 && write_permit_latch && feat[7:6] == 2'b11) prot = 1'b1;
        if (op == 8'h13) busy = 50;
        if (op == 8'h10 || op == 8'hd8 || op == 8'hff) write_permit_latch = 1'b0;
        if (op == 8'hff) busy = 30;
        if (op == 8'h1f && fa == 8'hb0) feat = sh;
        nb = 0;
        op = 8'h00;
    end
    // The internal operation time runs down on the system clock.
    always @(posedge clk_sys) if (busy > 0) busy = busy - 1;
endmodule

// ==== verification/test_snh_host.sv ====
// Self-checking testbench for the serial NAND host controller.
`timescale 1ns/1ps
module test_snh_host;
    typedef struct {snh_pkg::snh_kind_type k; logic q; logic qi; logic [23:0] a; logic [7:0] d;
        logic rf;} snh_row_type;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic cmd_valid = 1'b0;
    snh_pkg::snh_kind_type cmd_kind = snh_pkg::K_GETF;
    logic cmd_quad = 1'b0;
    logic cmd_qio = 1'b0;
    logic [11:0] cmd_len = 12'd2;
    logic [23:0] cmd_addr = 24'h000000;
    logic [7:0] cmd_data = 8'h00;
    wire cmd_ready, done, refused, wr_ready, chip_select_n, link_sclk, dout;
    wire [7:0] status;
    wire [3:0] lo, loe;
    int err_count = 0;
    int compares = 0;
    int gap = 0;
    int max_gap = 0;
    int nbytes = 0;
    logic rf;
    snh_row_type rows [23] = '{
        '{snh_pkg::K_SETF, 1'b0, 1'b0, 24'h0000b0, 8'h00, 1'b0},
        '{snh_pkg::K_LOAD, 1'b1, 1'b0, 24'h000000, 8'h00, 1'b1},
        '{snh_pkg::K_RLOAD, 1'b0, 1'b0, 24'h000000, 8'h00, 1'b1},
        '{snh_pkg::K_LOAD, 1'b0, 1'b0, 24'd2176, 8'h00, 1'b1},
        '{snh_pkg::K_LOAD, 1'b0, 1'b0, 24'h000000, 8'h00, 1'b0},
        '{snh_pkg::K_PREAD, 1'b0, 1'b0, 24'h000040, 8'h00, 1'b0},
        '{snh_pkg::K_RLOAD, 1'b0, 1'b0, 24'h000010, 8'h00, 1'b0},
        '{snh_pkg::K_RLOAD, 1'b1, 1'b0, 24'h000010, 8'h00, 1'b1},
        '{snh_pkg::K_SETF, 1'b0, 1'b0, 24'h0000b0, 8'h11, 1'b0},
        '{snh_pkg::K_LOAD, 1'b0, 1'b0, 24'd2112, 8'h00, 1'b1},
        '{snh_pkg::K_RLOAD, 1'b0, 1'b1, 24'h000000, 8'h00, 1'b0},
        '{snh_pkg::K_RLOAD, 1'b1, 1'b0, 24'h000020, 8'h00, 1'b0},
        '{snh_pkg::K_LOAD, 1'b1, 1'b0, 24'h000000, 8'h00, 1'b0},
        '{snh_pkg::K_PROG, 1'b0, 1'b0, 24'h000040, 8'h00, 1'b0},
        '{snh_pkg::K_ERASE, 1'b0, 1'b0, 24'h000040, 8'h00, 1'b0},
        '{snh_pkg::K_SETF, 1'b0, 1'b0, 24'h0000b0, 8'h40, 1'b0},
        '{snh_pkg::K_ERASE, 1'b0, 1'b0, 24'h000080, 8'h00, 1'b1},
        '{snh_pkg::K_PROG, 1'b0, 1'b0, 24'h000001, 8'h00, 1'b1},
        '{snh_pkg::K_PROG, 1'b0, 1'b0, 24'h000000, 8'h00, 1'b0},
        '{snh_pkg::K_SETF, 1'b0, 1'b0, 24'h0000b0, 8'hc0, 1'b0},
        '{snh_pkg::K_PROG, 1'b0, 1'b0, 24'h000000, 8'h00, 1'b0},
        '{snh_pkg::K_SETF, 1'b0, 1'b0, 24'h0000b0, 8'h40, 1'b0},
        '{snh_pkg::K_PROG, 1'b0, 1'b0, 24'h000001, 8'h00, 1'b1}
    };
    snh_host i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .ce(1'b1), .cmd_valid(cmd_valid),
        .cmd_kind(cmd_kind), .cmd_quad(cmd_quad), .cmd_qio(cmd_qio), .cmd_addr(cmd_addr),
        .cmd_len(cmd_len), .cmd_data(cmd_data), .cmd_ready(cmd_ready), .done(done),
        .refused(refused), .status(status), .wr_valid(1'b1), .wr_data(8'ha5),
        .wr_ready(wr_ready), .chip_select_n(chip_select_n), .link_sclk(link_sclk),
        .serial_line_zero_i(loe[0] ? lo[0] : 1'b1), .serial_line_zero_o(lo[0]),
        .serial_line_zero_oe(loe[0]), .serial_line_one_i(loe[1] ? lo[1] : dout),
        .serial_line_one_o(lo[1]), .serial_line_one_oe(loe[1]),
        .serial_line_two_i(loe[2] ? lo[2] : 1'b1), .serial_line_two_o(lo[2]),
        .serial_line_two_oe(loe[2]), .serial_line_three_i(loe[3] ? lo[3] : 1'b1),
        .serial_line_three_o(lo[3]), .serial_line_three_oe(loe[3]));
    snh_nand_model i_nand (.clk_sys(clk_sys), .chip_select_n(chip_select_n),
        .link_sclk(link_sclk), .din(lo[0]), .dout(dout));
    // The 50 MHz system clock.
    initial begin
        forever #10 clk_sys = ~clk_sys;
    end
    // Longest idle stretch of the select line, used to see the wait after a reset.
    always @(posedge clk_sys) begin
        gap = chip_select_n ? gap + 1 : 0;
        if (gap > max_gap) max_gap = gap;
        // Write data is always offered, so every ready cycle takes one byte.
        if (wr_ready) nbytes++;
    end
    // Compare and count; a mismatch is printed at once.
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Print the verdict and stop.
    task automatic end_sim();
        if (err_count == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Issue one command and wait, bounded, for done or refused.
    task automatic run(input snh_row_type r, output logic rfo);
        int i;
        @(negedge clk_sys);
        cmd_valid = 1'b1;
        cmd_kind = r.k;
        cmd_quad = r.q;
        cmd_qio = r.qi;
        cmd_addr = r.a;
        cmd_data = r.d;
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        for (i = 0; i < 20000; i++) begin
            if (done === 1'b1 || refused === 1'b1) break;
            @(negedge clk_sys);
        end
        rfo = refused;
        if (i == 20000) begin
            err_count++;
            end_sim();
        end
    endtask
    // Main sequence: reset, table of cases, load clamp, reset mid-frame with lock read-back, then the reset wait.
    initial begin
        repeat (5) @(negedge clk_sys);
        rst_n = 1'b1;
        check("idle_pins", {chip_select_n, cmd_ready, status}, {2'b11, 8'h00});
        foreach (rows[j]) begin
            run(rows[j], rf);
            check("refused", rf, rows[j].rf);
            if (!rows[j].rf && rows[j].k inside {snh_pkg::K_PROG, snh_pkg::K_ERASE})
                check("status", status, 8'h00);
        end
        // A long load near the end of the cache fetches only the room that is left.
        nbytes = 0;
        cmd_len = 12'd20;
        run('{snh_pkg::K_LOAD, 1'b0, 1'b0, 24'd2170, 8'h00, 1'b0}, rf);
        check("clamp_bytes", nbytes, int'(snh_pkg::LEN_FULL) - 2170);
        cmd_len = 12'd2;
        // Reset in the middle of a frame; the lock must then be read back from the part.
        @(negedge clk_sys);
        cmd_valid = 1'b1;
        cmd_kind = snh_pkg::K_PREAD;
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        repeat (20) @(negedge clk_sys);
        check("frame_open", chip_select_n, 1'b0);
        rst_n = 1'b0;
        @(negedge clk_sys);
        check("reset_pins", {chip_select_n, link_sclk, cmd_ready, wr_ready}, 4'b1010);
        rst_n = 1'b1;
        run('{snh_pkg::K_GETF, 1'b0, 1'b0, 24'h0000b0, 8'h00, 1'b0}, rf);
        check("lock_read", status, 8'hc0);
        run('{snh_pkg::K_PROG, 1'b0, 1'b0, 24'h000001, 8'h00, 1'b1}, rf);
        check("refused", rf, 1'b1);
        gap = 0;
        max_gap = 0;
        run('{snh_pkg::K_RESET, 1'b0, 1'b0, 24'h0, 8'h00, 1'b0}, rf);
        check("reset_wait", max_gap >= int'(snh_pkg::RST_WAIT_CYC), 1);
        check("reset_status", status, 8'h00);
        end_sim();
    end
endmodule
